// [core/ces_pkg.sv]
// constants shared by the communication error supervisor
// Functional notes
// [R1] retry limit holds 0 to 10, resets to 1
// [R2] consecutive receive errors beyond the limit trip per the stop mode
// [R3] retry limit at disable code: no trip, minor alarm instead
// [R4] minor alarm reaches a terminal only with function code 98 or 198
// [R5] retry counting only under the computer-link protocol, never under Modbus-RTU
// [R6] loss interval 0.1 s to 999.8 s: trip after silence that long
// [R7] loss interval at disable code: no signal-loss detection
// [R8] loss interval zero: trip on entering network operation mode
// [R9] any received frame clears the loss counter, whatever its station
// [R10] loss timing starts at first frame after entering network mode
// [R11] master sends a frame within every check interval
// [R12] stop mode 0 coasts, 1 decelerates then faults, 2 decelerates and restarts
// [R13] settings writable only while parameter access select is zero
// [R14] an error-free frame clears the consecutive error count
package ces_pkg;
    // clock and loss time base
    localparam int CLK_PERIOD_NS = 100;
    localparam int LOSS_UNIT_NS = 100_000_000;
    localparam int LOSS_UNIT_CYCLES = LOSS_UNIT_NS / CLK_PERIOD_NS;
    // widths
    localparam int SET_W = 16;
    localparam int ERR_W = 4;
    localparam int LCNT_W = 14;
    localparam int FUNC_W = 8;
    localparam int TERM_N = 3;
    localparam int ADDR_W = 8;
    localparam int IRQ_W = 4;
    // setting values
    localparam logic [15:0] SET_DISABLE = 16'h270F;
    localparam logic [15:0] RETRY_RESET = 16'h0001;
    localparam logic [15:0] RETRY_MAX = 16'h000A;
    localparam logic [15:0] LOSS_RESET = 16'h270F;
    localparam logic [15:0] LOSS_MAX = 16'h270E;
    localparam logic [15:0] ACCESS_RESET = 16'h0000;
    localparam logic [1:0] MODE_COAST = 2'h0;
    localparam logic [1:0] MODE_DECEL = 2'h1;
    localparam logic [1:0] MODE_RESTART = 2'h2;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [7:0] FUNC_RESET = 8'h00;
    localparam logic [7:0] FUNC_ALARM_POS = 8'h62;
    localparam logic [7:0] FUNC_ALARM_NEG = 8'hC6;
    // register byte offsets
    localparam logic [7:0] OFS_RETRY = 8'h00;
    localparam logic [7:0] OFS_LOSS = 8'h04;
    localparam logic [7:0] OFS_MODE = 8'h08;
    localparam logic [7:0] OFS_ACCESS = 8'h0C;
    localparam logic [7:0] OFS_FUNC0 = 8'h10;
    localparam logic [7:0] OFS_FUNC1 = 8'h14;
    localparam logic [7:0] OFS_FUNC2 = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h24;
    localparam logic [7:0] OFS_IRQ_EN = 8'h28;
    localparam logic [7:0] OFS_LOSS_CNT = 8'h2C;
    // status register fields
    localparam int STAT_FAULT = 0;
    localparam int STAT_MINOR = 1;
    localparam int STAT_ARMED = 2;
    localparam int STAT_ERR_LSB = 4;
    localparam int STAT_FSM_LSB = 8;
    localparam int STAT_FMODE_LSB = 12;
    // interrupt bits
    localparam int IRQ_RETRY = 0;
    localparam int IRQ_LOSS = 1;
    localparam int IRQ_MINOR = 2;
    localparam int IRQ_RESTART = 3;
    localparam logic [3:0] IRQ_RESET = 4'h0;
endpackage : ces_pkg

// [core/ces_tick.sv]
// prescaler giving one pulse per loss time unit
`timescale 1ns/1ns
module ces_tick #(
    parameter int CYCLES = 1000000
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clear_in,
    input wire logic run_in,
    output logic tick_out
);
    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } ces_tick_state_type;

    ces_tick_state_type r;
    ces_tick_state_type next_r;

    // count cycles, restart phase on clear
    always_comb
    begin
        next_r = r;
        next_r.tick = 1'b0;
        if (clear_in || !run_in)
        begin
            next_r.cnt = '0;
        end
        else if (r.cnt == CW'(CYCLES - 1))
        begin
            next_r.cnt = '0;
            next_r.tick = 1'b1;
        end
        else
        begin
            next_r.cnt = r.cnt + CW'(1);
        end
    end

    // state register
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign tick_out = r.tick;
endmodule : ces_tick

// [core/ces_supervisor.sv]
// link error supervisor: retry count, signal loss, stop mode, registers
`timescale 1ns/1ns
module ces_supervisor #(
    parameter int LOSS_UNIT_CYCLES = ces_pkg::LOSS_UNIT_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic frame_ok_in,
    input wire logic frame_err_in,
    input wire logic protocol_modbus_in,
    input wire logic net_mode_in,
    input wire logic motor_stopped_in,
    output logic coast_stop_out,
    output logic decel_stop_out,
    output logic link_fault_code_out,
    output logic fault_output_out,
    output logic minor_alarm_out,
    output logic [2:0] term_out,
    output logic irq_out
);
    typedef enum logic [2:0] {
        FLT_NONE,
        FLT_COAST,
        FLT_DECEL,
        FLT_TRIPPED,
        FLT_HOLD
    } ces_fault_type;

    typedef struct packed {
        logic [15:0] retry;
        logic [15:0] loss;
        logic [15:0] access;
        logic [1:0] mode;
        logic [2:0][7:0] func;
        logic [3:0] err_cnt;
        logic [13:0] loss_cnt;
        logic armed;
        logic net_prev;
        logic minor;
        ces_fault_type fsm;
        logic [1:0] flt_mode;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        logic [31:0] rdata;
        logic coast;
        logic decel;
        logic disp;
        logic fout;
        logic [2:0] term;
    } ces_state_type;

    ces_state_type r;
    ces_state_type next_r;
    logic tick;

    // legal retry setting: 0 to 10 or the disable code
    function automatic logic retry_ok(input logic [15:0] v);
        retry_ok = (v <= ces_pkg::RETRY_MAX) || (v == ces_pkg::SET_DISABLE);
    endfunction : retry_ok

    // legal loss setting: 0, 1 to 9998 tenths, or the disable code
    function automatic logic loss_ok(input logic [15:0] v);
        loss_ok = (v <= ces_pkg::LOSS_MAX) || (v == ces_pkg::SET_DISABLE);
    endfunction : loss_ok

    // terminal level for a function code and the alarm state
    function automatic logic term_level(input logic [7:0] code, input logic alarm);
        if (code == ces_pkg::FUNC_ALARM_POS)
        begin
            term_level = alarm;
        end
        else if (code == ces_pkg::FUNC_ALARM_NEG)
        begin
            term_level = !alarm;
        end
        else
        begin
            term_level = 1'b0;
        end
    endfunction : term_level

    // time base for the loss counter, rephased by every frame
    ces_tick #(
        .CYCLES(LOSS_UNIT_CYCLES)
    ) u_tick (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .clear_in(frame_ok_in || frame_err_in || !net_mode_in),
        .run_in(r.armed),
        .tick_out(tick)
    );

    // next state of the whole block
    always_comb
    begin
        logic set_wr;
        logic rx_any;
        logic loss_on;
        logic trip_retry;
        logic trip_loss;
        logic minor_evt;
        logic restart_evt;
        logic [3:0] irq_set;
        logic [3:0] irq_clr;
        logic [31:0] st;
        set_wr = 1'b0;
        rx_any = 1'b0;
        loss_on = 1'b0;
        trip_retry = 1'b0;
        trip_loss = 1'b0;
        minor_evt = 1'b0;
        restart_evt = 1'b0;
        irq_set = '0;
        irq_clr = '0;
        st = '0;
        next_r = r;

        // settings writes, gated by the access selector
        set_wr = reg_wr_in && (r.access == 16'h0000); // see [R13]
        if (set_wr && reg_addr_in == ces_pkg::OFS_RETRY && retry_ok(reg_wdata_in[15:0]))
        begin
            next_r.retry = reg_wdata_in[15:0]; // see [R1]
        end
        if (set_wr && reg_addr_in == ces_pkg::OFS_LOSS && loss_ok(reg_wdata_in[15:0]))
        begin
            next_r.loss = reg_wdata_in[15:0];
        end
        if (set_wr && reg_addr_in == ces_pkg::OFS_MODE && reg_wdata_in[31:2] == 30'h0
            && reg_wdata_in[1:0] <= ces_pkg::MODE_RESTART)
        begin
            next_r.mode = reg_wdata_in[1:0];
        end

        // ungated registers
        if (reg_wr_in && reg_addr_in == ces_pkg::OFS_ACCESS)
        begin
            next_r.access = reg_wdata_in[15:0];
        end
        if (reg_wr_in && reg_addr_in == ces_pkg::OFS_FUNC0)
        begin
            next_r.func[0] = reg_wdata_in[7:0];
        end
        if (reg_wr_in && reg_addr_in == ces_pkg::OFS_FUNC1)
        begin
            next_r.func[1] = reg_wdata_in[7:0];
        end
        if (reg_wr_in && reg_addr_in == ces_pkg::OFS_FUNC2)
        begin
            next_r.func[2] = reg_wdata_in[7:0];
        end
        if (reg_wr_in && reg_addr_in == ces_pkg::OFS_IRQ_EN)
        begin
            next_r.irq_en = reg_wdata_in[3:0];
        end
        if (reg_wr_in && reg_addr_in == ces_pkg::OFS_IRQ_CLR)
        begin
            irq_clr = reg_wdata_in[3:0];
        end

        // receive error run, computer-link protocol only
        if (frame_err_in && !protocol_modbus_in) // see [R5]
        begin
            if (r.retry == ces_pkg::SET_DISABLE)
            begin
                next_r.minor = 1'b1; // see [R3]
                minor_evt = !r.minor;
            end
            else
            begin
                if (r.err_cnt != 4'hF)
                begin
                    next_r.err_cnt = r.err_cnt + 4'h1;
                end
                if ((16'(r.err_cnt) + 16'h0001) > r.retry)
                begin
                    trip_retry = 1'b1; // see [R2]
                end
            end
        end
        // a clean frame ends the error run and the minor alarm
        if (frame_ok_in)
        begin
            next_r.err_cnt = '0; // see [R14]
            next_r.minor = 1'b0;
        end

        // signal loss detection
        rx_any = frame_ok_in || frame_err_in;
        loss_on = (r.loss != ces_pkg::SET_DISABLE) && (r.loss != 16'h0000); // see [R7]
        next_r.net_prev = net_mode_in;
        if (!net_mode_in)
        begin
            next_r.armed = 1'b0;
            next_r.loss_cnt = '0;
        end
        else if (rx_any)
        begin
            next_r.armed = loss_on; // see [R10]
            next_r.loss_cnt = '0; // see [R9]
        end
        else if (r.armed && tick && loss_on)
        begin
            next_r.loss_cnt = r.loss_cnt + 14'h0001;
            if ((r.loss_cnt + 14'h0001) >= r.loss[13:0])
            begin
                trip_loss = 1'b1; // see [R6]
            end
        end
        if (!loss_on)
        begin
            next_r.armed = 1'b0;
        end
        // zero interval faults on entry to network mode
        if (net_mode_in && !r.net_prev && r.loss == 16'h0000)
        begin
            trip_loss = 1'b1; // see [R8]
        end

        // fault response per captured stop mode
        unique case (r.fsm)
            FLT_NONE:
            begin
                if (trip_retry || trip_loss)
                begin
                    next_r.flt_mode = r.mode;
                    next_r.fsm = (r.mode == ces_pkg::MODE_COAST) ? FLT_COAST : FLT_DECEL; // see [R12]
                end
            end
            FLT_COAST:
            begin
                next_r.fsm = FLT_COAST;
            end
            FLT_DECEL:
            begin
                if (r.flt_mode == ces_pkg::MODE_RESTART && frame_ok_in)
                begin
                    next_r.fsm = FLT_NONE; // see [R12]
                    restart_evt = 1'b1;
                end
                else if (motor_stopped_in)
                begin
                    next_r.fsm = (r.flt_mode == ces_pkg::MODE_DECEL) ? FLT_TRIPPED : FLT_HOLD;
                end
            end
            FLT_TRIPPED:
            begin
                next_r.fsm = FLT_TRIPPED;
            end
            FLT_HOLD:
            begin
                if (frame_ok_in)
                begin
                    next_r.fsm = FLT_NONE; // see [R12]
                    restart_evt = 1'b1;
                end
            end
            default:
            begin
                next_r.fsm = FLT_NONE;
            end
        endcase

        // registered motor and fault outputs
        next_r.coast = (next_r.fsm == FLT_COAST);
        next_r.decel = (next_r.fsm == FLT_DECEL) || (next_r.fsm == FLT_TRIPPED)
            || (next_r.fsm == FLT_HOLD);
        next_r.disp = (next_r.fsm == FLT_COAST) || (next_r.fsm == FLT_TRIPPED)
            || (next_r.fsm == FLT_HOLD);
        next_r.fout = (next_r.fsm == FLT_COAST) || (next_r.fsm == FLT_TRIPPED); // see [R12]

        // alarm onto terminals by function code
        for (int i = 0; i < ces_pkg::TERM_N; i++)
        begin
            next_r.term[i] = term_level(next_r.func[i], next_r.minor); // see [R4]
        end

        // sticky interrupt status, set wins over clear
        irq_set[ces_pkg::IRQ_RETRY] = trip_retry;
        irq_set[ces_pkg::IRQ_LOSS] = trip_loss;
        irq_set[ces_pkg::IRQ_MINOR] = minor_evt;
        irq_set[ces_pkg::IRQ_RESTART] = restart_evt;
        next_r.irq_stat = (r.irq_stat & ~irq_clr) | irq_set;

        // status word
        st[ces_pkg::STAT_FAULT] = (r.fsm != FLT_NONE);
        st[ces_pkg::STAT_MINOR] = r.minor;
        st[ces_pkg::STAT_ARMED] = r.armed;
        st[ces_pkg::STAT_ERR_LSB +: 4] = r.err_cnt;
        st[ces_pkg::STAT_FSM_LSB +: 3] = r.fsm;
        st[ces_pkg::STAT_FMODE_LSB +: 2] = r.flt_mode;

        // read data stand for one cycle only
        next_r.rdata = '0;
        if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                ces_pkg::OFS_RETRY: next_r.rdata = {16'h0000, r.retry};
                ces_pkg::OFS_LOSS: next_r.rdata = {16'h0000, r.loss};
                ces_pkg::OFS_MODE: next_r.rdata = {30'h0, r.mode};
                ces_pkg::OFS_ACCESS: next_r.rdata = {16'h0000, r.access};
                ces_pkg::OFS_FUNC0: next_r.rdata = {24'h0, r.func[0]};
                ces_pkg::OFS_FUNC1: next_r.rdata = {24'h0, r.func[1]};
                ces_pkg::OFS_FUNC2: next_r.rdata = {24'h0, r.func[2]};
                ces_pkg::OFS_STATUS: next_r.rdata = st;
                ces_pkg::OFS_IRQ_STAT: next_r.rdata = {28'h0, r.irq_stat};
                ces_pkg::OFS_IRQ_EN: next_r.rdata = {28'h0, r.irq_en};
                ces_pkg::OFS_LOSS_CNT: next_r.rdata = {18'h0, r.loss_cnt};
                default: next_r.rdata = '0;
            endcase
        end
    end

    // state register with reset values
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            r <= '0;
            r.retry <= ces_pkg::RETRY_RESET;
            r.loss <= ces_pkg::LOSS_RESET;
            r.access <= ces_pkg::ACCESS_RESET;
            r.mode <= ces_pkg::MODE_RESET;
            r.func <= {3{ces_pkg::FUNC_RESET}};
            r.fsm <= FLT_NONE;
            r.irq_stat <= ces_pkg::IRQ_RESET;
            r.irq_en <= ces_pkg::IRQ_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // outputs
    assign reg_rdata_out = r.rdata;
    assign coast_stop_out = r.coast;
    assign decel_stop_out = r.decel;
    assign link_fault_code_out = r.disp;
    assign fault_output_out = r.fout;
    assign minor_alarm_out = r.minor;
    assign term_out = r.term;
    assign irq_out = |(r.irq_stat & r.irq_en); // level interrupt
endmodule : ces_supervisor

// [verif/ces_chk.sv]
// port assertions for the link error supervisor
`timescale 1ns/1ns
module ces_chk (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic frame_ok_in,
    input wire logic protocol_modbus_in,
    input wire logic net_mode_in,
    input wire logic motor_stopped_in,
    input wire logic coast_stop_out,
    input wire logic decel_stop_out,
    input wire logic link_fault_code_out,
    input wire logic fault_output_out
);
    // one clock domain, all checks off in reset
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    // read data only right after a read strobe
    property p_rdata_idle;
        !reg_rd_in |=> reg_rdata_out == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data out of slot");
    // coast stop shows the code and the fault output
    property p_coast_all;
        coast_stop_out |-> fault_output_out && link_fault_code_out && !decel_stop_out;
    endproperty
    a_coast_all: assert property (p_coast_all) else $error("coast without fault signs");
    // coast stop is kept until reset
    property p_coast_hold;
        coast_stop_out |=> coast_stop_out;
    endproperty
    a_coast_hold: assert property (p_coast_hold) else $error("coast stop released");
    // fault output is kept until reset
    property p_fout_hold;
        fault_output_out |=> fault_output_out;
    endproperty
    a_fout_hold: assert property (p_fout_hold) else $error("fault output released");
    // fault output never without the code
    property p_fout_code;
        fault_output_out |-> link_fault_code_out;
    endproperty
    a_fout_code: assert property (p_fout_code) else $error("fault output without code");
    // decelerating stop and coasting stop exclude each other
    property p_decel_excl;
        decel_stop_out |-> !coast_stop_out;
    endproperty
    a_decel_excl: assert property (p_decel_excl) else $error("coast during decel");
    // once stopped in a decel fault, the code follows
    property p_stop_code;
        decel_stop_out && !link_fault_code_out && motor_stopped_in && !frame_ok_in |-> ##[1:3] link_fault_code_out;
    endproperty
    a_stop_code: assert property (p_stop_code) else $error("code missing after stop");
    // code of a decel fault only after standstill
    property p_code_late;
        $rose(link_fault_code_out) && decel_stop_out |-> $past(motor_stopped_in);
    endproperty
    a_code_late: assert property (p_code_late) else $error("code before standstill");
    // second protocol outside network mode never trips; a decel fault may still finish
    property p_modbus_quiet;
        $past(protocol_modbus_in) && !$past(net_mode_in) && !decel_stop_out |-> !$rose(link_fault_code_out);
    endproperty
    a_modbus_quiet: assert property (p_modbus_quiet) else $error("trip under second protocol");
endmodule : ces_chk

bind ces_supervisor ces_chk ces_chk_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .frame_ok_in(frame_ok_in), .protocol_modbus_in(protocol_modbus_in),
    .net_mode_in(net_mode_in), .motor_stopped_in(motor_stopped_in), .coast_stop_out(coast_stop_out),
    .decel_stop_out(decel_stop_out), .link_fault_code_out(link_fault_code_out),
    .fault_output_out(fault_output_out));

// [verif/ces_host.sv]
// host master model: frames arrive as one-cycle pulses
`timescale 1ns/1ns
module ces_host (
    input wire logic core_clk_in,
    output logic frame_ok_out,
    output logic frame_err_out
);
    // quiet link at start
    initial
    begin
        frame_ok_out = 1'b0;
        frame_err_out = 1'b0;
    end
    // wait a gap, then one frame, clean or with a receive error
    task automatic send(input int gap, input bit err);
        repeat (gap) @(posedge core_clk_in);
        @(posedge core_clk_in);
        frame_ok_out <= !err;
        frame_err_out <= err;
        @(posedge core_clk_in);
        frame_ok_out <= 1'b0;
        frame_err_out <= 1'b0;
    endtask : send
endmodule : ces_host

// [verif/testbench.sv]
// self-checking bench for the link error supervisor
`timescale 1ns/1ns
module testbench;
    logic core_clk, rst, wr_s, rd_s, fok, ferr, modbus, net, stopped;
    logic coast, decel, code, fout, minor, irq;
    logic [2:0] term;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, v, seed;
    int mdl [0:15];
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int i;

    ces_supervisor #(.LOSS_UNIT_CYCLES(10)) ces_supervisor_inst (
        .core_clk_in(core_clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
        .reg_rd_in(rd_s), .reg_rdata_out(rdata), .frame_ok_in(fok), .frame_err_in(ferr),
        .protocol_modbus_in(modbus), .net_mode_in(net), .motor_stopped_in(stopped), .coast_stop_out(coast),
        .decel_stop_out(decel), .link_fault_code_out(code), .fault_output_out(fout), .minor_alarm_out(minor),
        .term_out(term), .irq_out(irq));
    ces_host ces_host_inst (.core_clk_in(core_clk), .frame_ok_out(fok), .frame_err_out(ferr));

    // 10 MHz clock
    always #50 core_clk = ~core_clk;

    // hang guard
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            mismatches++;
            close_out();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic close_out();
        if (mismatches == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // stop outputs as {coast, decel, code, fault output}
    task automatic outs(input logic [3:0] e);
        chk(32'({coast, decel, code, fout}), 32'(e));
    endtask : outs

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : wait_cyc

    // bus write, model keeps what the block must accept
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        k = a >> 2;
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge core_clk);
        wr_s <= 1'b0;
        if (k > 2 || (mdl[3] == 0 && (k == 0 ? (d <= 32'hA || d == 32'h270F) : d <= (k == 1 ? 32'h270F : 32'h2))))
            if (k <= 6 || k == 10)
                mdl[k] = d & (k == 10 ? 32'hF : (k > 3 ? 32'hFF : 32'hFFFF));
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge core_clk);
        rd_s <= 1'b0;
        @(negedge core_clk);
        d = rdata;
    endtask : rd

    task automatic rd_chk(input logic [7:0] a);
        rd(a, v);
        chk(v, 32'(mdl[a >> 2]));
    endtask : rd_chk

    task automatic do_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        net <= 1'b0;
        modbus <= 1'b0;
        stopped <= 1'b0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        mdl = '{default: 0};
        mdl[0] = 32'h1;
        mdl[1] = 32'h270F;
    endtask : do_reset

    initial
    begin
        core_clk = 1'b0;
        rst = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wr_s = 1'b0;
        rd_s = 1'b0;
        modbus = 1'b0;
        net = 1'b0;
        stopped = 1'b0;
        seed = 32'hFCEEB308;
        do_reset();
        // reset values, unmapped place included
        for (i = 0; i < 13; i++)
            rd_chk(8'(i * 4));
        // random settings, out-of-range ones refused
        for (i = 0; i < 24; i++)
        begin
            seed = lfsr(seed);
            wr(8'((i % 3) * 4), seed & (i % 3 == 1 ? 32'h3FFF : 32'hF));
            rd_chk(8'((i % 3) * 4));
        end
        // settings locked while access select is non-zero
        wr(ces_pkg::OFS_ACCESS, 32'h1);
        wr(ces_pkg::OFS_RETRY, 32'h5);
        rd_chk(ces_pkg::OFS_RETRY);
        do_reset();
        // error run broken by a clean frame, then a coast trip
        wr(ces_pkg::OFS_IRQ_EN, 32'hF);
        ces_host_inst.send(0, 1);
        ces_host_inst.send(0, 0);
        ces_host_inst.send(0, 1);
        wait_cyc(3);
        outs(4'h0);
        ces_host_inst.send(0, 1);
        wait_cyc(3);
        outs(4'hB);
        chk(32'(irq), 32'h1);
        rd(ces_pkg::OFS_IRQ_STAT, v);
        chk(v, 32'h1);
        // status: fault, error run of two, coast state
        rd(ces_pkg::OFS_STATUS, v);
        chk(v, 32'h121);
        wr(ces_pkg::OFS_IRQ_CLR, 32'h1);
        wait_cyc(1);
        chk(32'(irq), 32'h0);
        do_reset();
        // errors under the second protocol
        @(posedge core_clk) modbus <= 1'b1;
        repeat (4) ces_host_inst.send(0, 1);
        wait_cyc(3);
        outs(4'h0);
        do_reset();
        // retry disable code gives the minor alarm on terminals
        wr(ces_pkg::OFS_RETRY, 32'h270F);
        wr(ces_pkg::OFS_FUNC0, 32'h62);
        wr(ces_pkg::OFS_FUNC1, 32'hC6);
        @(posedge core_clk) net <= 1'b1;
        wait_cyc(2);
        chk(32'(term), 32'h2);
        ces_host_inst.send(0, 1);
        ces_host_inst.send(0, 1);
        wait_cyc(3);
        chk(32'({minor, term}), 32'h9);
        outs(4'h0);
        rd(ces_pkg::OFS_IRQ_STAT, v);
        chk(v, 32'h4);
        wait_cyc(60);
        outs(4'h0);
        // minor alarm only, loss timer never armed
        rd(ces_pkg::OFS_STATUS, v);
        chk(v, 32'h2);
        do_reset();
        // signal loss in decel mode
        wr(ces_pkg::OFS_LOSS, 32'h3);
        wr(ces_pkg::OFS_MODE, 32'h1);
        @(posedge core_clk) net <= 1'b1;
        wait_cyc(60);
        outs(4'h0);
        for (i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            ces_host_inst.send(int'(seed[4:0]) % 25 + 1, 0);
        end
        wait_cyc(20);
        outs(4'h0);
        wait_cyc(20);
        outs(4'h4);
        @(posedge core_clk) stopped <= 1'b1;
        wait_cyc(4);
        outs(4'h7);
        rd(ces_pkg::OFS_IRQ_STAT, v);
        chk(v, 32'h2);
        do_reset();
        // zero interval trips on entering network mode, restart mode
        wr(ces_pkg::OFS_LOSS, 32'h0);
        wr(ces_pkg::OFS_MODE, 32'h2);
        @(posedge core_clk) net <= 1'b1;
        wait_cyc(4);
        outs(4'h4);
        @(posedge core_clk) stopped <= 1'b1;
        wait_cyc(4);
        outs(4'h6);
        ces_host_inst.send(0, 0);
        wait_cyc(4);
        outs(4'h0);
        // loss trip and automatic restart both left their marks
        rd(ces_pkg::OFS_IRQ_STAT, v);
        chk(v, 32'hA);
        close_out();
    end
endmodule : testbench
